// *** rtl/lvd_pkg.sv ***
// constants for the low-voltage detect control block
package lvd_pkg;
  // byte addresses on the register bus
  localparam logic [15:0] CTRL_ADDR = 16'h3040;
  localparam logic [15:0] EVT_STAT_ADDR = 16'h3044;
  localparam logic [15:0] EVT_MASK_ADDR = 16'h3048;
  localparam int ADDR_W = 16;
  // control register field positions
  localparam int WARN_FLAG_BIT = 7;
  localparam int WARN_ACK_BIT = 6;
  localparam int WARN_IRQ_EN_BIT = 5;
  localparam int DETECT_RESET_EN_BIT = 4;
  localparam int DETECT_STOP_EN_BIT = 3;
  localparam int DETECT_EN_BIT = 2;
  localparam int REF_BUF_DRIVE_SEL_BIT = 1;
  localparam int REF_BUF_EN_BIT = 0;
  // control register reset value
  localparam logic [7:0] CTRL_RESET = 8'h1c;
  // event status and mask layout
  localparam int EVT_WARN_BIT = 0;
  localparam int EVT_DETECT_BIT = 1;
  localparam int EVT_W = 2;
  localparam logic [1:0] EVT_RESET = 2'h0;
  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] RDATA_RESET = 32'h0;
  // synchroniser width: warning and detect comparator levels
  localparam int SYNC_W = 2;
  localparam int SYNC_WARN = 0;
  localparam int SYNC_DETECT = 1;
endpackage : lvd_pkg

// *** rtl/lvd_sync.sv ***
// two-flop synchroniser for the analog comparator levels
`timescale 1ns/100ps
`default_nettype none
module lvd_sync (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic [lvd_pkg::SYNC_W-1:0] async_in, // levels from another domain
  output logic [lvd_pkg::SYNC_W-1:0] sync_out // levels safe to read
);
  logic [lvd_pkg::SYNC_W-1:0] meta;
  logic [lvd_pkg::SYNC_W-1:0] next_meta;
  logic [lvd_pkg::SYNC_W-1:0] next_sync_out;

  // first stage feeds only the second stage
  always_comb begin
    next_meta = async_in;
    next_sync_out = meta;
  end

  // register both stages
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= next_meta;
      sync_out <= next_sync_out;
    end
  end
endmodule : lvd_sync
`default_nettype wire

// *** rtl/lvd_ctrl.sv ***
// low-voltage detect status and control register with AHB-Lite slave
//
// What this block does
// - The warning flag sets while the supply is below the warning trip level; reset holds it at 0.
// - Writing 1 to bit 6 clears the warning flag only if the warning is gone.
// - Bit 5 enables an interrupt request while the warning flag is 1.
// - Bit 4 with the detect enable set makes a detect event request a reset.
// - Detect reset enable and detect enable take only the first write after reset.
// - Bit 3 keeps detection running in stop mode when detect is enabled.
// - Bit 2 enables detection and gates the other detect control bits.
// - Bit 1 selects high drive of the reference buffer while it is enabled.
// - Bit 0 enables the reference buffer towards the converter channel.
// - The control register decodes at address 0x3040.
//
// The register offsets and the AHB-Lite slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module lvd_ctrl (
  input wire logic CLK_SYS, // system clock, 25 MHz
  input wire logic RESET, // async reset, active high
  input wire logic HSEL, // slave select
  input wire logic [31:0] HADDR, // byte address
  input wire logic [1:0] HTRANS, // transfer type
  input wire logic HWRITE, // write when high
  input wire logic [2:0] HSIZE, // transfer size
  input wire logic [31:0] HWDATA, // write data
  input wire logic HREADY, // bus ready
  output logic HREADYOUT, // slave ready
  output logic HRESP, // always OKAY
  output logic [31:0] HRDATA, // read data
  input wire logic SUPPLY_WARNING, // supply below warning trip level
  input wire logic SUPPLY_DETECT, // supply below detect trip level
  input wire logic STOP_MODE, // core is in stop mode
  output logic DETECT_ACTIVE, // detect comparator powered
  output logic DETECT_RESET_REQ, // request a device reset
  output logic WARN_IRQ_REQ, // warning interrupt request
  output logic REF_BUF_EN, // reference buffer enable
  output logic REF_BUF_HIGH_DRIVE, // reference buffer high drive
  output logic IRQ // masked event interrupt
);
  logic [lvd_pkg::SYNC_W-1:0] lvl;
  logic warn_lvl;
  logic detect_lvl;

  // bus phase state
  logic rd_pend;
  logic rd_go;
  logic wr_pend;
  logic [lvd_pkg::ADDR_W-1:0] addr_q;
  logic next_rd_pend;
  logic next_rd_go;
  logic next_wr_pend;
  logic [lvd_pkg::ADDR_W-1:0] next_addr_q;
  logic [31:0] next_hrdata;

  // register state
  logic warn_flag;
  logic warn_irq_en;
  logic detect_reset_en;
  logic detect_stop_en;
  logic detect_en;
  logic ref_buf_drive_sel;
  logic ref_buf_en;
  logic once_done;
  logic [lvd_pkg::EVT_W-1:0] evt_stat;
  logic [lvd_pkg::EVT_W-1:0] evt_mask;
  logic warn_prev;
  logic detect_prev;
  logic next_warn_flag;
  logic next_warn_irq_en;
  logic next_detect_reset_en;
  logic next_detect_stop_en;
  logic next_detect_en;
  logic next_ref_buf_drive_sel;
  logic next_ref_buf_en;
  logic next_once_done;
  logic [lvd_pkg::EVT_W-1:0] next_evt_stat;
  logic [lvd_pkg::EVT_W-1:0] next_evt_mask;
  logic next_detect_reset_req;

  // decoded strobes
  logic addr_phase;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_stat;
  logic running;
  logic [lvd_pkg::EVT_W-1:0] evt_set;
  logic [7:0] wbyte;

  // address decode, used for both read and write
  function automatic logic hit(input logic [lvd_pkg::ADDR_W-1:0] a,
                               input logic [lvd_pkg::ADDR_W-1:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  // comparator levels come from the analog domain
  // both levels cross as plain levels, so no handshake is needed between domains
  lvd_sync u_sync (
    .clk(CLK_SYS),
    .rst(RESET),
    .async_in({SUPPLY_DETECT, SUPPLY_WARNING}),
    .sync_out(lvl)
  );

  assign warn_lvl = lvl[lvd_pkg::SYNC_WARN];
  assign detect_lvl = lvl[lvd_pkg::SYNC_DETECT];

  // control register image as software reads it
  function automatic logic [7:0] ctrl_image(input logic f, input logic ie,
                                            input logic re, input logic se,
                                            input logic de, input logic ds,
                                            input logic be);
    logic [7:0] v;
    v = 8'h00;
    v[lvd_pkg::WARN_FLAG_BIT] = f;
    v[lvd_pkg::WARN_ACK_BIT] = 1'b0;
    v[lvd_pkg::WARN_IRQ_EN_BIT] = ie;
    v[lvd_pkg::DETECT_RESET_EN_BIT] = re;
    v[lvd_pkg::DETECT_STOP_EN_BIT] = se;
    v[lvd_pkg::DETECT_EN_BIT] = de;
    v[lvd_pkg::REF_BUF_DRIVE_SEL_BIT] = ds;
    v[lvd_pkg::REF_BUF_EN_BIT] = be;
    ctrl_image = v;
  endfunction : ctrl_image

  // slave is ready except in the first data-phase cycle of a read
  // the one wait state lets the read image settle into flops before it is shown
  // writes need no wait: the data phase byte lands at the closing edge
  assign HREADYOUT = ~rd_pend;
  assign HRESP = 1'b0;
  assign addr_phase = HSEL & HREADY & (HTRANS == lvd_pkg::HTRANS_NONSEQ | HTRANS[1]);
  // only byte lane 0 carries register bits; the transfer size is not decoded
  // strobes fire in the data phase, from the address held since the address phase
  assign wbyte = HWDATA[7:0];
  assign wr_ctrl = wr_pend & hit(addr_q, lvd_pkg::CTRL_ADDR);
  assign wr_mask = wr_pend & hit(addr_q, lvd_pkg::EVT_MASK_ADDR);
  assign rd_stat = rd_pend & hit(addr_q, lvd_pkg::EVT_STAT_ADDR);

  // bus phase tracking and read data capture
  always_comb begin
    next_rd_pend = addr_phase & ~HWRITE;
    next_wr_pend = addr_phase & HWRITE;
    next_rd_go = rd_pend;
    next_addr_q = addr_phase ? HADDR[lvd_pkg::ADDR_W-1:0] : addr_q;
    next_hrdata = HRDATA;
    // unmapped offsets read as zero
    if (rd_pend) begin
      next_hrdata = 32'h0;
      if (hit(addr_q, lvd_pkg::CTRL_ADDR)) begin
        next_hrdata[7:0] = ctrl_image(warn_flag, warn_irq_en, detect_reset_en,
                                      detect_stop_en, detect_en,
                                      ref_buf_drive_sel, ref_buf_en);
      end else if (hit(addr_q, lvd_pkg::EVT_STAT_ADDR)) begin
        next_hrdata[lvd_pkg::EVT_W-1:0] = evt_stat;
      end else if (hit(addr_q, lvd_pkg::EVT_MASK_ADDR)) begin
        next_hrdata[lvd_pkg::EVT_W-1:0] = evt_mask;
      end
    end
  end

  // register the bus phase state
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      rd_pend <= 1'b0;
      rd_go <= 1'b0;
      wr_pend <= 1'b0;
      addr_q <= '0;
      HRDATA <= lvd_pkg::RDATA_RESET;
    end else begin
      rd_pend <= next_rd_pend;
      rd_go <= next_rd_go;
      wr_pend <= next_wr_pend;
      addr_q <= next_addr_q;
      HRDATA <= next_hrdata;
    end
  end

  // detection runs when enabled, and in stop mode only if allowed
  // the stop gate follows the mode pin at once, so the comparator powers down
  // in the same cycle that the core enters stop
  assign running = detect_en & (~STOP_MODE | detect_stop_en);
  assign evt_set[lvd_pkg::EVT_WARN_BIT] = warn_lvl & ~warn_prev;
  assign evt_set[lvd_pkg::EVT_DETECT_BIT] = running & detect_lvl & ~detect_prev;

  // next values of the control register and event bits
  always_comb begin
    next_warn_flag = warn_flag;
    next_warn_irq_en = warn_irq_en;
    next_detect_reset_en = detect_reset_en;
    next_detect_stop_en = detect_stop_en;
    next_detect_en = detect_en;
    next_ref_buf_drive_sel = ref_buf_drive_sel;
    next_ref_buf_en = ref_buf_en;
    next_once_done = once_done;
    next_evt_stat = evt_stat;
    next_evt_mask = evt_mask;
    if (wr_ctrl) begin
      // a 1 on the acknowledge bit clears a flag whose cause is gone
      if (wbyte[lvd_pkg::WARN_ACK_BIT] & ~warn_lvl) begin
        next_warn_flag = 1'b0;
      end
      next_warn_irq_en = wbyte[lvd_pkg::WARN_IRQ_EN_BIT];
      next_detect_stop_en = wbyte[lvd_pkg::DETECT_STOP_EN_BIT];
      next_ref_buf_drive_sel = wbyte[lvd_pkg::REF_BUF_DRIVE_SEL_BIT];
      next_ref_buf_en = wbyte[lvd_pkg::REF_BUF_EN_BIT];
      // bits 4 and 2 lock together on the first write, so code that armed
      // the reset path cannot disarm it later by accident
      if (!once_done) begin
        next_detect_reset_en = wbyte[lvd_pkg::DETECT_RESET_EN_BIT];
        next_detect_en = wbyte[lvd_pkg::DETECT_EN_BIT];
        next_once_done = 1'b1;
      end
    end
    // a warning level sets the flag and wins over the acknowledge
    if (warn_lvl) begin
      next_warn_flag = 1'b1;
    end
    if (wr_mask) begin
      next_evt_mask = HWDATA[lvd_pkg::EVT_W-1:0];
    end
    // reading the status clears it, a new event in the same cycle wins
    if (rd_stat) begin
      next_evt_stat = '0;
    end
    next_evt_stat = next_evt_stat | evt_set;
    // the request is a level: it stays up as long as the low supply is seen
    next_detect_reset_req = detect_en & detect_reset_en & running & detect_lvl;
  end

  // register the control state
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      warn_flag <= lvd_pkg::CTRL_RESET[lvd_pkg::WARN_FLAG_BIT];
      warn_irq_en <= lvd_pkg::CTRL_RESET[lvd_pkg::WARN_IRQ_EN_BIT];
      detect_reset_en <= lvd_pkg::CTRL_RESET[lvd_pkg::DETECT_RESET_EN_BIT];
      detect_stop_en <= lvd_pkg::CTRL_RESET[lvd_pkg::DETECT_STOP_EN_BIT];
      detect_en <= lvd_pkg::CTRL_RESET[lvd_pkg::DETECT_EN_BIT];
      ref_buf_drive_sel <= lvd_pkg::CTRL_RESET[lvd_pkg::REF_BUF_DRIVE_SEL_BIT];
      ref_buf_en <= lvd_pkg::CTRL_RESET[lvd_pkg::REF_BUF_EN_BIT];
      once_done <= 1'b0;
      evt_stat <= lvd_pkg::EVT_RESET;
      evt_mask <= lvd_pkg::EVT_RESET;
      warn_prev <= 1'b0;
      detect_prev <= 1'b0;
      DETECT_RESET_REQ <= 1'b0;
    end else begin
      warn_flag <= next_warn_flag;
      warn_irq_en <= next_warn_irq_en;
      detect_reset_en <= next_detect_reset_en;
      detect_stop_en <= next_detect_stop_en;
      detect_en <= next_detect_en;
      ref_buf_drive_sel <= next_ref_buf_drive_sel;
      ref_buf_en <= next_ref_buf_en;
      once_done <= next_once_done;
      evt_stat <= next_evt_stat;
      evt_mask <= next_evt_mask;
      warn_prev <= warn_lvl;
      detect_prev <= detect_lvl;
      DETECT_RESET_REQ <= next_detect_reset_req;
    end
  end

  // outputs to the analog side and interrupt controller
  assign DETECT_ACTIVE = running;
  assign WARN_IRQ_REQ = warn_irq_en & warn_flag;
  assign REF_BUF_EN = ref_buf_en;
  assign REF_BUF_HIGH_DRIVE = ref_buf_en & ref_buf_drive_sel;
  // event interrupt is a level, high while any unmasked status bit is set
  assign IRQ = |(evt_stat & evt_mask);
endmodule : lvd_ctrl
`default_nettype wire

// *** test/lvd_ctrl_monitor.sv ***
// port assertions for the low-voltage detect control block
`timescale 1ns/100ps
`default_nettype none
module lvd_ctrl_monitor (
  input wire logic CLK_SYS, // clock
  input wire logic RESET, // reset
  input wire logic HSEL, // select
  input wire logic [31:0] HADDR, // address
  input wire logic [1:0] HTRANS, // transfer type
  input wire logic HWRITE, // write
  input wire logic HREADY, // bus ready
  input wire logic HREADYOUT, // slave ready
  input wire logic HRESP, // response
  input wire logic [31:0] HRDATA, // read data
  input wire logic SUPPLY_WARNING, // warning level
  input wire logic SUPPLY_DETECT, // detect level
  input wire logic STOP_MODE, // stop mode
  input wire logic DETECT_ACTIVE, // detect running
  input wire logic DETECT_RESET_REQ, // reset request
  input wire logic REF_BUF_EN, // buffer on
  input wire logic REF_BUF_HIGH_DRIVE // high drive
);
  logic take;
  logic rd_ctrl;
  logic wtk;
  logic wdn;
  // accepted transfer, and a read of the control register
  assign take = HSEL && HREADY && HTRANS[1];
  assign rd_ctrl = take && !HWRITE && (HADDR[15:0] == lvd_pkg::CTRL_ADDR);
  // marks the write data phase and the cycle after, when control bits move
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      wtk <= 1'b0;
      wdn <= 1'b0;
    end else begin
      wtk <= take && HWRITE;
      wdn <= wtk;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // response is always okay, writes take no wait, reads take one
  property p_okay; !HRESP; endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_wr_ready; take && HWRITE |=> HREADYOUT; endproperty
  a_wr_ready: assert property (p_wr_ready) else $error("write stalled");
  property p_rd_wait; take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read timing wrong");
  // acknowledge bit reads 0, flag reads 1 under a lasting warning
  property p_ack_zero; rd_ctrl |=> ##1 !HRDATA[6]; endproperty
  a_ack_zero: assert property (p_ack_zero) else $error("ack bit read as 1");
  property p_warn_set; SUPPLY_WARNING [*4] ##0 rd_ctrl |=> ##1 HRDATA[7]; endproperty
  a_warn_set: assert property (p_warn_set) else $error("warning flag not set");
  // reset request needs a detect level three edges back and running detection
  property p_rst_req; DETECT_RESET_REQ |-> $past(SUPPLY_DETECT, 3) && $past(DETECT_ACTIVE);
  endproperty
  a_rst_req: assert property (p_rst_req) else $error("reset request without cause");
  property p_active; $stable(STOP_MODE) && !wdn |-> $stable(DETECT_ACTIVE); endproperty
  a_active: assert property (p_active) else $error("detect state moved alone");
  property p_drive; REF_BUF_HIGH_DRIVE |-> REF_BUF_EN; endproperty
  a_drive: assert property (p_drive) else $error("high drive with buffer off");
endmodule : lvd_ctrl_monitor

bind lvd_ctrl lvd_ctrl_monitor mon (.CLK_SYS(CLK_SYS), .RESET(RESET), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .SUPPLY_WARNING(SUPPLY_WARNING),
  .SUPPLY_DETECT(SUPPLY_DETECT), .STOP_MODE(STOP_MODE), .DETECT_ACTIVE(DETECT_ACTIVE),
  .DETECT_RESET_REQ(DETECT_RESET_REQ), .REF_BUF_EN(REF_BUF_EN),
  .REF_BUF_HIGH_DRIVE(REF_BUF_HIGH_DRIVE));
`default_nettype wire

// *** test/tb_lvd_ctrl.sv ***
// self-checking bench for the low-voltage detect control block
`timescale 1ns/100ps
`default_nettype none
module tb_lvd_ctrl;
  localparam logic [15:0] ca = lvd_pkg::CTRL_ADDR;
  logic clk, rst, hsel, hwrite, hro, hresp, sw, sd, stp, act, rreq, wirq, ben, bhi, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] d;
  int err_count, checked;
  integer seed;
  lvd_ctrl dut (.CLK_SYS(clk), .RESET(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hro), .HREADYOUT(hro),
    .HRESP(hresp), .HRDATA(hrdata), .SUPPLY_WARNING(sw), .SUPPLY_DETECT(sd),
    .STOP_MODE(stp), .DETECT_ACTIVE(act), .DETECT_RESET_REQ(rreq), .WARN_IRQ_REQ(wirq),
    .REF_BUF_EN(ben), .REF_BUF_HIGH_DRIVE(bhi), .IRQ(irq));
  // 25 MHz clock
  always #20 clk = ~clk;
  // expected control read: locked bits from lk, flag f, ack always 0
  function automatic logic [7:0] ctl(input logic [7:0] v, input logic f, input logic [1:0] lk);
    ctl = {f, 1'b0, v[5], lk[1], v[3], lk[0], v[1:0]};
  endfunction : ctl
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("Error t=%0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_bit(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask : chk_bit
  // waits for ready with a bound, a hang ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hro !== 1'b1 && n < 50);
    if (hro !== 1'b1) begin
      err_count++;
      $display("Error t=%0t bus hang", $time);
      final_report();
    end
  endtask : wait_rdy
  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] v);
    hsel <= 1'b1;
    htrans <= lvd_pkg::HTRANS_NONSEQ;
    haddr <= {16'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, v};
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h0);
    chk(rd, e);
  endtask : rchk
  task automatic do_reset();
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset
  // main sequence
  initial begin
    {clk, rst, hsel, hwrite, sw, sd, stp, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    err_count = 0;
    checked = 0;
    seed = 32'he10e166d;
    do_reset();
    rchk(ca, 32'h1c);
    chk_bit(act, 1'b1);
    bus(1'b1, ca, 8'h00);
    sd <= 1'b1;
    repeat (6) @(posedge clk);
    chk_bit(act, 1'b0);
    chk_bit(rreq, 1'b0);
    rchk(lvd_pkg::EVT_STAT_ADDR, 32'h0);
    bus(1'b1, ca, 8'h14);
    rchk(ca, 32'h00);
    sd <= 1'b0;
    $display("test lock done");
    do_reset();
    bus(1'b1, ca, 8'h17);
    rchk(ca, 32'h17);
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      bus(1'b1, ca, d);
      rchk(ca, {24'h0, ctl(d, 1'b0, 2'b11)});
      chk_bit(ben, d[0]);
      chk_bit(bhi, d[0] & d[1]);
      chk_bit(wirq, 1'b0);
    end
    bus(1'b1, ca, 8'h14);
    sd <= 1'b1;
    repeat (5) @(posedge clk);
    chk_bit(rreq, 1'b1);
    stp <= 1'b1;
    repeat (5) @(posedge clk);
    chk_bit(act, 1'b0);
    chk_bit(rreq, 1'b0);
    bus(1'b1, ca, 8'h1c);
    repeat (5) @(posedge clk);
    chk_bit(rreq, 1'b1);
    sd <= 1'b0;
    stp <= 1'b0;
    $display("test detect done");
    bus(1'b1, ca, 8'h54);
    sw <= 1'b1;
    repeat (5) @(posedge clk);
    chk_bit(wirq, 1'b0);
    rchk(ca, 32'h94);
    bus(1'b1, ca, 8'h34);
    @(posedge clk);
    chk_bit(wirq, 1'b1);
    bus(1'b1, ca, 8'h74);
    rchk(ca, 32'hb4);
    sw <= 1'b0;
    repeat (5) @(posedge clk);
    bus(1'b1, ca, 8'h34);
    rchk(ca, 32'hb4);
    bus(1'b1, ca, 8'h74);
    rchk(ca, 32'h34);
    chk_bit(wirq, 1'b0);
    $display("test warning done");
    bus(1'b1, lvd_pkg::EVT_MASK_ADDR, 8'h00);
    @(posedge clk);
    chk_bit(irq, 1'b0);
    bus(1'b1, lvd_pkg::EVT_MASK_ADDR, 8'h03);
    @(posedge clk);
    chk_bit(irq, 1'b1);
    rchk(lvd_pkg::EVT_STAT_ADDR, 32'h3);
    chk_bit(irq, 1'b0);
    rchk(lvd_pkg::EVT_STAT_ADDR, 32'h0);
    bus(1'b1, 16'h3050, 8'hff);
    rchk(16'h3050, 32'h0);
    rchk(ca, 32'h34);
    $display("test events done");
    final_report();
  end
endmodule : tb_lvd_ctrl
`default_nettype wire
